//--- verilog/psi_pkg.sv
// constants shared by the power and status indicator controller
// assumes a 10 MHz system clock; all counts are derived from that rate
package psi_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned BLINK_HALF_S = 1;
  localparam int unsigned BEEP_SLOW_S = 2;
  localparam int unsigned PROTECT_MIN = 2;
  localparam int unsigned SEC_CYCLES = CLK_HZ;
  localparam int unsigned BEEP_LEN_CYC = CLK_HZ / 10;
  localparam int unsigned BEEP_FAST_CYC = CLK_HZ / 2;
  localparam int unsigned PROTECT_S = PROTECT_MIN * 60;
  // ==========================================================
  // battery thresholds: percent and millivolts
  localparam logic [6:0] WARN_PCT = 7'h0A;
  localparam logic [6:0] LOW_PCT = 7'h04;
  localparam logic [15:0] DEAD_MV = 16'h2328;
  // ==========================================================
  // display selection codes
  localparam logic [1:0] DISP_PANEL = 2'h0;
  localparam logic [1:0] DISP_EXT = 2'h1;
  localparam logic [1:0] DISP_BOTH = 2'h2;
  // lid actions
  localparam logic [1:0] LID_EXT = 2'h0;
  localparam logic [1:0] LID_PANEL_OFF = 2'h1;
  localparam logic [1:0] LID_SUSPEND = 2'h2;
  // brightness
  localparam logic [2:0] BRIGHT_RST = 3'h7;
  localparam logic [2:0] BRIGHT_MAX = 3'h7;
  // battery status led colours
  localparam logic [1:0] COL_OFF = 2'h0;
  localparam logic [1:0] COL_RED = 2'h1;
  localparam logic [1:0] COL_GREEN = 2'h2;
  localparam logic [1:0] COL_AMBER = 2'h3;
  // ==========================================================
  // power management and battery states
  typedef enum logic [4:0] {
    PM_FULL = 5'h01,
    PM_DOZE = 5'h02,
    PM_STBY = 5'h04,
    PM_SDRAM = 5'h08,
    PM_SDISK = 5'h10
  } psi_pm_t;
  typedef enum logic [3:0] {
    BAT_OK = 4'h1,
    BAT_WARN = 4'h2,
    BAT_LOW = 4'h4,
    BAT_DEAD = 4'h8
  } psi_bat_t;
endpackage

//--- verilog/psi_ctrl.sv
// power management and status indicator controller: leds, battery alarms,
// hot keys, lid switch, idle state stepping and fan pwm
// assumes key and lid inputs are single-cycle pulses or levels from logic
// on sys_clk_i, and that the fan pwm counter runs on the same clock
//
// Overview of operation
// - on AC the AC led is steady; in DRAM suspend it blinks 1 s
// - AC led dark when off, on battery, or in disk suspend
// - on battery the battery led is steady; DRAM suspend blinks 1 s
// - battery led dark when off, on AC, or in disk suspend
// - status led off normally; at 10 percent red, flashing, beep every 2 s
// - with AC present status led green when full, amber when charging
// - warning beeps sound only while the beep enable is set
// - protection enabled forces disk suspend 2 minutes after warning
// - below 4 percent after warning, low state beeps twice per second
// - at 9 volts the system is shut down
// - display key cycles panel, external, both
// - brightness keys step down or up; ignored on passive panels
// - battery warning key inverts the beep enable
// - suspend key forces disk or DRAM suspend per configuration
// - lid closure while powered runs the configured action
// - doze throttles the processor between run and stop grant
// - standby holds stop grant, backlight off, disk and floppy down
// - enabled activity monitors advance the state when idle
// - fan speed is pwm derived from cpu temperature
module psi_ctrl #(
  parameter int unsigned SEC_CYC = psi_pkg::SEC_CYCLES,
  parameter int unsigned IDLE_SEC = 60,
  parameter int unsigned DOZE_PERIOD = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic power_on_i,
  input wire logic ac_present_i,
  input wire logic bat_full_i,
  input wire logic bat_charging_i,
  input wire logic [6:0] bat_pct_i,
  input wire logic [15:0] bat_mv_i,
  input wire logic key_display_i,
  input wire logic key_bright_dn_i,
  input wire logic key_bright_up_i,
  input wire logic key_beep_i,
  input wire logic key_suspend_i,
  input wire logic wake_i,
  input wire logic lid_closed_i,
  input wire logic [1:0] cfg_lid_action_i,
  input wire logic cfg_susp_disk_i,
  input wire logic cfg_protect_en_i,
  input wire logic cfg_passive_panel_i,
  input wire logic cfg_mon_video_i,
  input wire logic cfg_mon_disk_i,
  input wire logic video_act_i,
  input wire logic disk_act_i,
  input wire logic [7:0] cpu_temp_i,
  output logic led_ac_o,
  output logic led_bat_o,
  output logic [1:0] led_stat_o,
  output logic beep_o,
  output logic beep_en_o,
  output logic [1:0] disp_sel_o,
  output logic [2:0] bright_o,
  output logic panel_on_o,
  output logic cpu_stop_grant_o,
  output logic hdd_spin_down_o,
  output logic fdd_standby_o,
  output logic [4:0] pm_state_o,
  output logic shutdown_o,
  output logic fan_pwm_o
);
  initial begin
    if (SEC_CYC < 10 || IDLE_SEC < 1 || DOZE_PERIOD < 2) $error("psi_ctrl: bad parameter");
  end

  // ==========================================================
  // prescaler and timebase
  logic [31:0] pre_ff;
  logic sec_tick;
  logic blink_ff;
  logic [7:0] beep_sec_ff;
  logic [31:0] half_ff;
  logic half_tick;
  // one second tick shared by blink, beep and protection timers
  assign sec_tick = (pre_ff == SEC_CYC - 1);
  assign half_tick = (half_ff == SEC_CYC / 2 - 1);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pre_ff <= 32'h0;
    end else if (sec_tick) begin
      pre_ff <= 32'h0;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      half_ff <= 32'h0;
    end else if (half_tick) begin
      half_ff <= 32'h0;
    end else begin
      half_ff <= half_ff + 32'h1;
    end
  end
  // blink phase toggles each second: on 1 s, off 1 s
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_ff <= 1'b0;
      beep_sec_ff <= 8'h0;
    end else if (sec_tick) begin
      blink_ff <= ~blink_ff;
      beep_sec_ff <= beep_sec_ff + 8'h1;
    end
  end

  // ==========================================================
  // power management state
  psi_pkg::psi_pm_t pm_ff;
  psi_pkg::psi_pm_t nxt_pm;
  psi_pkg::psi_bat_t bat_ff;
  logic [7:0] prot_ff;
  logic [15:0] idle_ff;
  logic idle_now;
  logic lid_prev_ff;
  logic lid_event;
  logic susp_req;
  logic beep_en_ff;
  psi_pkg::psi_pm_t susp_target;

  // idle only counts when a monitor is enabled and its activity is absent
  assign idle_now = (cfg_mon_video_i || cfg_mon_disk_i) &&
                    !(cfg_mon_video_i && video_act_i) && !(cfg_mon_disk_i && disk_act_i);
  assign lid_event = lid_closed_i && !lid_prev_ff && power_on_i;
  assign susp_target = cfg_susp_disk_i ? psi_pkg::PM_SDISK : psi_pkg::PM_SDRAM;
  // hot key or lid suspend, disk or dram chosen by configuration
  assign susp_req = key_suspend_i || (lid_event && cfg_lid_action_i == psi_pkg::LID_SUSPEND);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lid_prev_ff <= 1'b0;
    end else begin
      lid_prev_ff <= lid_closed_i;
    end
  end

  // idle seconds counter; any monitored activity restarts it
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_ff <= 16'h0;
    end else if (!idle_now || nxt_pm != pm_ff) begin
      idle_ff <= 16'h0;
    end else if (sec_tick && idle_ff != 16'hFFFF) begin
      idle_ff <= idle_ff + 16'h1;
    end
  end

  // state stepping; protection and suspend requests take priority over idle
  always_comb begin
    nxt_pm = pm_ff;
    unique case (pm_ff)
      psi_pkg::PM_FULL, psi_pkg::PM_DOZE, psi_pkg::PM_STBY: begin
        if (!power_on_i) begin
          nxt_pm = psi_pkg::PM_FULL;
        end else if (cfg_protect_en_i && bat_ff != psi_pkg::BAT_OK && prot_ff >= 8'(psi_pkg::PROTECT_S)) begin
          nxt_pm = psi_pkg::PM_SDISK;
        end else if (susp_req) begin
          nxt_pm = susp_target;
        end else if (idle_ff >= 16'(IDLE_SEC)) begin
          nxt_pm = (pm_ff == psi_pkg::PM_FULL) ? psi_pkg::PM_DOZE :
                   (pm_ff == psi_pkg::PM_DOZE) ? psi_pkg::PM_STBY : susp_target;
        end else if (!idle_now && pm_ff != psi_pkg::PM_FULL) begin
          nxt_pm = psi_pkg::PM_FULL;
        end
      end
      psi_pkg::PM_SDRAM, psi_pkg::PM_SDISK: begin
        if (wake_i || !power_on_i) begin
          nxt_pm = psi_pkg::PM_FULL;
        end
      end
      default: nxt_pm = psi_pkg::PM_FULL;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pm_ff <= psi_pkg::PM_FULL;
    end else begin
      pm_ff <= nxt_pm;
    end
  end

  // ==========================================================
  // battery states: warning at or below 10, low below 4, dead at 9 volts
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bat_ff <= psi_pkg::BAT_OK;
    end else if (ac_present_i || !power_on_i) begin
      bat_ff <= psi_pkg::BAT_OK;
    end else if (bat_mv_i <= psi_pkg::DEAD_MV) begin
      bat_ff <= psi_pkg::BAT_DEAD;
    end else if (bat_ff != psi_pkg::BAT_OK && bat_pct_i < psi_pkg::LOW_PCT) begin
      bat_ff <= psi_pkg::BAT_LOW;
    end else if (bat_ff == psi_pkg::BAT_OK && bat_pct_i <= psi_pkg::WARN_PCT) begin
      bat_ff <= psi_pkg::BAT_WARN;
    end
  end
  // protection timer counts seconds since the warning state was entered
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prot_ff <= 8'h0;
    end else if (bat_ff == psi_pkg::BAT_OK) begin
      prot_ff <= 8'h0;
    end else if (sec_tick && prot_ff != 8'hFF) begin
      prot_ff <= prot_ff + 8'h1;
    end
  end
  assign shutdown_o = (bat_ff == psi_pkg::BAT_DEAD);

  // ==========================================================
  // hot keys
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      beep_en_ff <= 1'b1;
    end else if (key_beep_i) begin
      beep_en_ff <= ~beep_en_ff;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      disp_sel_o <= psi_pkg::DISP_PANEL;
    end else if (lid_event && cfg_lid_action_i == psi_pkg::LID_EXT) begin
      disp_sel_o <= psi_pkg::DISP_EXT;
    end else if (key_display_i) begin
      disp_sel_o <= (disp_sel_o == psi_pkg::DISP_BOTH) ? psi_pkg::DISP_PANEL : disp_sel_o + 2'h1;
    end
  end
  // passive panels have fixed brightness, so the keys are ignored
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bright_o <= psi_pkg::BRIGHT_RST;
    end else if (!cfg_passive_panel_i) begin
      if (key_bright_up_i && bright_o != psi_pkg::BRIGHT_MAX) begin
        bright_o <= bright_o + 3'h1;
      end else if (key_bright_dn_i && !key_bright_up_i && bright_o != 3'h0) begin
        bright_o <= bright_o - 3'h1;
      end
    end
  end
  // lid panel-off holds until the lid opens again
  logic lid_off_ff;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lid_off_ff <= 1'b0;
    end else if (!lid_closed_i) begin
      lid_off_ff <= 1'b0;
    end else if (lid_event && cfg_lid_action_i == psi_pkg::LID_PANEL_OFF) begin
      lid_off_ff <= 1'b1;
    end
  end

  // ==========================================================
  // device controls per state
  logic [7:0] doze_ff;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      doze_ff <= 8'h0;
    end else if (doze_ff >= 8'(DOZE_PERIOD - 1)) begin
      doze_ff <= 8'h0;
    end else begin
      doze_ff <= doze_ff + 8'h1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cpu_stop_grant_o <= 1'b0;
      hdd_spin_down_o <= 1'b0;
      fdd_standby_o <= 1'b0;
      panel_on_o <= 1'b0;
    end else begin
      // doze alternates run and stop grant, half of each period
      cpu_stop_grant_o <= (nxt_pm == psi_pkg::PM_STBY) ||
                          (nxt_pm == psi_pkg::PM_DOZE && doze_ff >= 8'(DOZE_PERIOD / 2));
      hdd_spin_down_o <= (nxt_pm == psi_pkg::PM_STBY);
      fdd_standby_o <= (nxt_pm == psi_pkg::PM_STBY);
      panel_on_o <= power_on_i && !lid_off_ff && (nxt_pm == psi_pkg::PM_FULL || nxt_pm == psi_pkg::PM_DOZE);
    end
  end

  // ==========================================================
  // leds and beeper
  logic run;
  logic warn;
  assign run = power_on_i && pm_ff != psi_pkg::PM_SDISK;
  assign warn = !ac_present_i && (bat_ff == psi_pkg::BAT_WARN || bat_ff == psi_pkg::BAT_LOW);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      led_ac_o <= 1'b0;
      led_bat_o <= 1'b0;
      led_stat_o <= psi_pkg::COL_OFF;
    end else begin
      // steady while running, 1 s blink in dram suspend, dark otherwise
      led_ac_o <= run && ac_present_i && (pm_ff != psi_pkg::PM_SDRAM || blink_ff);
      led_bat_o <= run && !ac_present_i && (pm_ff != psi_pkg::PM_SDRAM || blink_ff);
      if (ac_present_i) begin
        led_stat_o <= bat_full_i ? psi_pkg::COL_GREEN :
                      bat_charging_i ? psi_pkg::COL_AMBER : psi_pkg::COL_OFF;
      end else if (warn && power_on_i) begin
        led_stat_o <= blink_ff ? psi_pkg::COL_RED : psi_pkg::COL_OFF;
      end else begin
        led_stat_o <= psi_pkg::COL_OFF;
      end
    end
  end
  // beep pulse: each even second when warning, each half second when low
  logic [23:0] beep_len_ff;
  logic beep_start;
  assign beep_start = warn && beep_en_ff && power_on_i &&
                      ((bat_ff == psi_pkg::BAT_WARN && sec_tick && beep_sec_ff[0]) ||
                       (bat_ff == psi_pkg::BAT_LOW && half_tick));
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      beep_len_ff <= 24'h0;
    end else if (beep_start) begin
      // a tenth of the configured second, so a shortened second keeps beeps apart
      beep_len_ff <= 24'(SEC_CYC / 10);
    end else if (beep_len_ff != 24'h0 && !(beep_en_ff && warn)) begin
      beep_len_ff <= 24'h0;
    end else if (beep_len_ff != 24'h0) begin
      beep_len_ff <= beep_len_ff - 24'h1;
    end
  end
  assign beep_o = (beep_len_ff != 24'h0);
  assign beep_en_o = beep_en_ff;
  assign pm_state_o = pm_ff;

  // ==========================================================
  // fan pwm: duty rises with cpu temperature
  logic [7:0] pwm_cnt_ff;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwm_cnt_ff <= 8'h0;
      fan_pwm_o <= 1'b0;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + 8'h1;
      fan_pwm_o <= power_on_i && (pwm_cnt_ff < cpu_temp_i);
    end
  end

  // ==========================================================
  // checks
  property p_ac_dark_on_bat;
    @(posedge sys_clk_i) disable iff (!rst_b_i) !ac_present_i |=> !led_ac_o;
  endproperty
  a_ac_dark_on_bat: assert property (p_ac_dark_on_bat) else $error("ac led lit on battery");
  property p_bat_dark_on_ac;
    @(posedge sys_clk_i) disable iff (!rst_b_i) ac_present_i |=> !led_bat_o;
  endproperty
  a_bat_dark_on_ac: assert property (p_bat_dark_on_ac) else $error("battery led lit on ac");
  property p_disk_dark;
    @(posedge sys_clk_i) disable iff (!rst_b_i) pm_ff == psi_pkg::PM_SDISK |=> !led_ac_o && !led_bat_o;
  endproperty
  a_disk_dark: assert property (p_disk_dark) else $error("power led lit in disk suspend");
  property p_beep_gate;
    @(posedge sys_clk_i) disable iff (!rst_b_i) !beep_en_ff |=> !beep_o;
  endproperty
  a_beep_gate: assert property (p_beep_gate) else $error("beep while disabled");
  property p_beep_toggle;
    @(posedge sys_clk_i) disable iff (!rst_b_i) key_beep_i |=> beep_en_ff != $past(beep_en_ff);
  endproperty
  a_beep_toggle: assert property (p_beep_toggle) else $error("beep enable not inverted");
  property p_disp_cycle;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      key_display_i && !lid_event && disp_sel_o == psi_pkg::DISP_BOTH |=> disp_sel_o == psi_pkg::DISP_PANEL;
  endproperty
  a_disp_cycle: assert property (p_disp_cycle) else $error("display did not wrap");
  property p_passive;
    @(posedge sys_clk_i) disable iff (!rst_b_i) cfg_passive_panel_i |=> $stable(bright_o);
  endproperty
  a_passive: assert property (p_passive) else $error("brightness moved on passive panel");
  property p_standby;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      pm_ff == psi_pkg::PM_STBY |-> cpu_stop_grant_o && hdd_spin_down_o && fdd_standby_o && !panel_on_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby controls wrong");
  property p_dead;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      power_on_i && !ac_present_i && bat_mv_i <= psi_pkg::DEAD_MV |=> shutdown_o;
  endproperty
  a_dead: assert property (p_dead) else $error("no shutdown at dead voltage");
  property p_susp_key;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      key_suspend_i && power_on_i && pm_ff == psi_pkg::PM_FULL && bat_ff == psi_pkg::BAT_OK && cfg_susp_disk_i
      |=> pm_ff == psi_pkg::PM_SDISK;
  endproperty
  a_susp_key: assert property (p_susp_key) else $error("suspend key ignored");
endmodule

//--- verif/psi_gauge.sv
// battery gauge model feeding the controller's capacity and voltage inputs
// assumes the bench sets target readings; the gauge walks toward them
module psi_gauge (
  input wire logic sys_clk_i,
  input wire logic [6:0] tgt_pct_i,
  input wire logic [15:0] tgt_mv_i,
  output logic [6:0] bat_pct_o,
  output logic [15:0] bat_mv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // readings
  // full pack at power up
  initial begin
    bat_pct_o = 7'h64;
    bat_mv_o = 16'h3138;
  end
  // a real gauge drifts, so percent steps one count and voltage 100 mV per cycle
  always @(negedge sys_clk_i) begin
    if (bat_pct_o > tgt_pct_i) bat_pct_o <= bat_pct_o - 7'h01;
    else if (bat_pct_o < tgt_pct_i) bat_pct_o <= bat_pct_o + 7'h01;
    if (bat_mv_o > tgt_mv_i + 16'h0064) bat_mv_o <= bat_mv_o - 16'h0064;
    else if (bat_mv_o + 16'h0064 < tgt_mv_i) bat_mv_o <= bat_mv_o + 16'h0064;
    else bat_mv_o <= tgt_mv_i;
  end
endmodule

//--- verif/psi_ctrl_tb.sv
// self-checking bench for the power and status indicator controller
// assumes a shortened second of SC cycles and one idle second per step
module power_status_indicator_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 20;
  // ==========================================================
  // stimulus and wiring
  logic sys_clk_i = 0, rst_b_i = 0, power_on_i = 1, ac_present_i = 1;
  logic bat_full_i = 0, bat_charging_i = 1, lid_closed_i = 0, cfg_susp_disk_i = 0;
  logic cfg_protect_en_i = 0, cfg_passive_panel_i = 0, cfg_mon_video_i = 0;
  logic cfg_mon_disk_i = 0, video_act_i = 0, disk_act_i = 0;
  logic [1:0] cfg_lid_action_i = 2'h3;
  logic [7:0] cpu_temp_i = 8'h40;
  logic [5:0] keys = 6'h00;
  logic [6:0] tgt_pct = 7'h64;
  logic [15:0] tgt_mv = 16'h3138;
  wire logic [6:0] bat_pct_i;
  wire logic [15:0] bat_mv_i;
  logic led_ac_o, led_bat_o, beep_o, beep_en_o, panel_on_o, cpu_stop_grant_o;
  logic hdd_spin_down_o, fdd_standby_o, shutdown_o, fan_pwm_o;
  logic [1:0] led_stat_o, disp_sel_o;
  logic [2:0] bright_o;
  logic [4:0] pm_state_o;
  int errors = 0, check_count = 0, seed = 32'hC43320B1;
  int e_disp = 0, e_br = 7, e_be = 1, t, n_ac, n_bat, n_red, n_bp, n_sg, n_fan;
  // free-running 10 MHz clock
  always #50 sys_clk_i = ~sys_clk_i;
  psi_gauge GAUGE (.sys_clk_i, .tgt_pct_i(tgt_pct), .tgt_mv_i(tgt_mv), .bat_pct_o(bat_pct_i),
    .bat_mv_o(bat_mv_i));
  psi_ctrl #(.SEC_CYC(SC), .IDLE_SEC(1), .DOZE_PERIOD(4)) DUT (.sys_clk_i, .rst_b_i, .power_on_i,
    .ac_present_i, .bat_full_i, .bat_charging_i, .bat_pct_i, .bat_mv_i, .key_display_i(keys[0]),
    .key_bright_dn_i(keys[1]), .key_bright_up_i(keys[2]), .key_beep_i(keys[3]), .key_suspend_i(keys[4]),
    .wake_i(keys[5]), .lid_closed_i, .cfg_lid_action_i, .cfg_susp_disk_i, .cfg_protect_en_i,
    .cfg_passive_panel_i, .cfg_mon_video_i, .cfg_mon_disk_i, .video_act_i, .disk_act_i, .cpu_temp_i,
    .led_ac_o, .led_bat_o, .led_stat_o, .beep_o, .beep_en_o, .disp_sel_o, .bright_o, .panel_on_o,
    .cpu_stop_grant_o, .hdd_spin_down_o, .fdd_standby_o, .pm_state_o, .shutdown_o, .fan_pwm_o);
  // ==========================================================
  // helpers
  task automatic end_of_test;
    if (errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one-cycle key pulse, launched and dropped at falling edges
  task automatic press(input int k);
    keys[k] = 1'b1;
    @(negedge sys_clk_i);
    keys[k] = 1'b0;
    @(negedge sys_clk_i);
  endtask
  // a hang here counts as a mismatch and ends the run
  task automatic wait_pm(input logic [4:0] v, input int lim);
    for (t = 0; t < lim && pm_state_o !== v; t++) @(negedge sys_clk_i);
    if (pm_state_o !== v) begin
      chk(pm_state_o, v);
      end_of_test();
    end
  endtask
  // tallies of levels and beep onsets over a window of n cycles
  task automatic watch(input int n);
    logic pb;
    pb = beep_o;
    {n_ac, n_bat, n_red, n_bp, n_sg, n_fan} = '0;
    repeat (n) begin
      @(negedge sys_clk_i);
      n_ac += led_ac_o;
      n_bat += led_bat_o;
      n_red += (led_stat_o === psi_pkg::COL_RED);
      n_bp += (beep_o && !pb);
      pb = beep_o;
      n_sg += cpu_stop_grant_o;
      n_fan += fan_pwm_o;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(negedge sys_clk_i);
    chk({beep_en_o, bright_o, pm_state_o, led_ac_o, led_stat_o}, 16'h0F08);
    rst_b_i = 1;
    repeat (3) @(negedge sys_clk_i);
    chk({led_ac_o, led_bat_o, led_stat_o}, 16'h0B);
    {bat_full_i, bat_charging_i} = 2'h2;
    repeat (3) @(negedge sys_clk_i);
    chk(led_stat_o, psi_pkg::COL_GREEN);
    ac_present_i = 0;
    repeat (3) @(negedge sys_clk_i);
    chk({led_ac_o, led_bat_o, led_stat_o}, 16'h04);
    power_on_i = 0;
    repeat (3) @(negedge sys_clk_i);
    chk({led_ac_o, led_bat_o}, 16'h00);
    {power_on_i, ac_present_i} = 2'h3;
    // display cycling, brightness clamp and passive refusal, beep toggle
    repeat (($random(seed) & 7) + 3) begin
      press(0);
      e_disp = (e_disp + 1) % 3;
      chk(disp_sel_o, e_disp);
    end
    for (int i = 0; i < 12; i++) begin
      press(i < 9 ? 1 : 2);
      e_br = i < 9 ? (e_br > 0 ? e_br - 1 : 0) : e_br + 1;
      chk(bright_o, e_br);
    end
    cfg_passive_panel_i = 1;
    press(2);
    press(1);
    chk(bright_o, e_br);
    cfg_passive_panel_i = 0;
    repeat (2) begin
      press(3);
      e_be = 1 - e_be;
      chk(beep_en_o, e_be);
    end
    // dram suspend on ac then on battery, then disk suspend
    for (int b = 0; b < 2; b++) begin
      ac_present_i = b[0] ? 1'b0 : 1'b1;
      press(4);
      wait_pm(psi_pkg::PM_SDRAM, 4);
      watch(4 * SC);
      chk({8'(n_ac), 8'(n_bat)}, b ? {8'h00, 8'(2 * SC)} : {8'(2 * SC), 8'h00});
      press(5);
      wait_pm(psi_pkg::PM_FULL, 4);
    end
    cfg_susp_disk_i = 1;
    press(4);
    wait_pm(psi_pkg::PM_SDISK, 4);
    watch(2 * SC);
    chk({8'(n_ac), 8'(n_bat)}, 16'h0000);
    press(5);
    wait_pm(psi_pkg::PM_FULL, 4);
    // lid closure: external monitor, panel off, then configured suspend
    cfg_lid_action_i = psi_pkg::LID_EXT;
    lid_closed_i = 1;
    repeat (3) @(negedge sys_clk_i);
    chk(disp_sel_o, psi_pkg::DISP_EXT);
    lid_closed_i = 0;
    repeat (3) @(negedge sys_clk_i);
    cfg_lid_action_i = psi_pkg::LID_PANEL_OFF;
    lid_closed_i = 1;
    repeat (3) @(negedge sys_clk_i);
    chk(panel_on_o, 0);
    lid_closed_i = 0;
    cfg_lid_action_i = psi_pkg::LID_SUSPEND;
    repeat (3) @(negedge sys_clk_i);
    lid_closed_i = 1;
    wait_pm(psi_pkg::PM_SDISK, 4);
    lid_closed_i = 0;
    press(5);
    wait_pm(psi_pkg::PM_FULL, 4);
    // idle stepping under video monitoring; disk activity holds full on
    cfg_mon_video_i = 1;
    wait_pm(psi_pkg::PM_DOZE, SC + 4);
    watch(8);
    chk(n_sg, 4);
    wait_pm(psi_pkg::PM_STBY, SC + 4);
    chk({cpu_stop_grant_o, panel_on_o, hdd_spin_down_o, fdd_standby_o}, 16'hB);
    video_act_i = 1;
    wait_pm(psi_pkg::PM_FULL, 4);
    {video_act_i, cfg_mon_video_i, cfg_mon_disk_i, disk_act_i} = 4'h3;
    repeat (3 * SC) @(negedge sys_clk_i);
    chk(pm_state_o, psi_pkg::PM_FULL);
    {cfg_mon_disk_i, disk_act_i} = 2'h0;
    cpu_temp_i = 8'($random(seed));
    watch(256);
    chk(n_fan, cpu_temp_i);
    // battery warning, silenced warning, low state
    ac_present_i = 0;
    tgt_pct = 7'h0A;
    repeat (100) @(negedge sys_clk_i);
    watch(8 * SC);
    chk({n_red > 0, n_red < 8 * SC, n_bp == 4, shutdown_o}, 16'hE);
    press(3);
    watch(4 * SC);
    chk({n_red > 0, 8'(n_bp)}, 16'h100);
    press(3);
    tgt_pct = 7'h03;
    repeat (10) @(negedge sys_clk_i);
    watch(4 * SC);
    chk(n_bp, 8);
    chk(pm_state_o, psi_pkg::PM_FULL);
    // protection: disk suspend two minutes after warning
    ac_present_i = 1;
    tgt_pct = 7'h09;
    repeat (10) @(negedge sys_clk_i);
    {cfg_protect_en_i, ac_present_i} = 2'h2;
    wait_pm(psi_pkg::PM_SDISK, 120 * SC + 10);
    // the timer counts whole seconds, so the first one may be partial
    chk(t > 119 * SC - 5 && t < 120 * SC + 5, 1);
    press(5);
    // battery dead at 9 volts
    tgt_mv = 16'h2328;
    for (t = 0; t < 60 && shutdown_o !== 1'b1; t++) @(negedge sys_clk_i);
    chk({shutdown_o, bat_mv_i}, 17'h12328);
    end_of_test();
  end
endmodule
